// ==== bench/host_model.sv ====
module host_model (
	// Clock
	input wire logic clk,
	// Programming pins
	output logic serial_clock,
	output logic serial_data,
	output logic load_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Idle pins
	// The shift clock stands low between frames.
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end

	// ==========================================================
	// Frames
	// Each bit gets a 160 ns slot: data settles for four cycles, then the
	// clock goes high for four, so the sampled edge never sees a change.
	task automatic send_bits(input logic [159:0] w, input int n);
		@(posedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data <= w[i];
			repeat (4) @(posedge clk);
			serial_clock <= 1'b1;
			repeat (4) @(posedge clk);
			serial_clock <= 1'b0;
		end
		// A released line shows the inverse, so a stale bit never matches.
		serial_data <= ~w[0];
	endtask

	// The strobe level moves only on a clock edge.
	task automatic set_strobe(input logic v);
		@(posedge clk) load_strobe <= v;
	endtask
endmodule

// ==== bench/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals
	localparam int LOCK = 20;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic pwr_n = 1'b1;
	logic ref_in = 1'b0;
	logic sclk;
	logic sdata;
	logic strobe;
	logic cap_en;
	logic locked;
	logic [3:0] ref_d = 4'h0;
	logic [31:0] rng = 32'h8A9B;
	int ref_cnt = 0;
	int err_total = 0;
	int checks = 0;
	cfg_loader_pkg::clock_pins_s pins;
	tri0 [8:0] out_clock;

	// ==========================================================
	// Clocks and pads
	// System clock; the reference runs at one sixteenth of it.
	always #10 clk = ~clk;
	always @(posedge clk) begin
		ref_cnt <= ref_cnt + 1;
		if (ref_cnt % 8 == 7) ref_in <= ~ref_in;
		ref_d <= {ref_d[2:0], ref_in};
	end
	// Output pads with the internal pull-down when not driven.
	for (genvar k = 0; k < 9; k++) begin : g_pad
		assign out_clock[k] = pins.oe[k] ? pins.level[k] : 1'bz;
	end

	serial_clock_config_loader #(.LOCK_CYCLES(LOCK)) dut (.clk(clk),
		.resetn(resetn), .clk_en(clk_en), .serial_clock(sclk),
		.serial_data(sdata), .load_strobe(strobe),
		.power_down_tristate_n(pwr_n), .reference_input(ref_in),
		.clock_pins(pins), .xtal_cap_enable(cap_en), .config_locked(locked));
	host_model host (.clk(clk), .serial_clock(sclk), .serial_data(sdata),
		.load_strobe(strobe));

	// ==========================================================
	// Reference model
	// The shift register is a queue of the last 160 bits seen on the pins.
	// The model latch copies it on a strobe rise or a shift under strobe.
	logic bits_q[$];
	logic [159:0] model_latch = 160'h0;

	function automatic logic [159:0] model_word();
		logic [159:0] v;
		v = 160'h0;
		foreach (bits_q[j]) v[bits_q.size() - 1 - j] = bits_q[j];
		return v;
	endfunction

	always @(posedge sclk) begin
		bits_q.push_back(sdata);
		if (bits_q.size() > 160) void'(bits_q.pop_front());
		if (strobe) model_latch = model_word();
	end

	always @(posedge strobe) model_latch = model_word();

	// ==========================================================
	// Helpers
	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic rand_word(output logic [159:0] w);
		for (int i = 0; i < 5; i++) begin
			rng = xs(rng);
			w[32*i +: 32] = rng;
		end
	endtask

	// The strobe stays high four cycles, above the minimum width.
	task automatic pulse();
		host.set_strobe(1'b1);
		repeat (3) @(posedge clk);
		host.set_strobe(1'b0);
	endtask

	// Bypassed outputs are compared only while the reference is steady,
	// which tolerates a cycle of pipeline slack; divided ones are counted.
	task automatic check_outputs(input logic [159:0] w, input logic prog);
		int tog [9];
		int d [9];
		logic [8:0] last;
		last = out_clock;
		for (int k = 0; k < 9; k++) begin
			tog[k] = 0;
			d[k] = prog ? int'(w[4*k+1 +: 4]) : 0;
		end
		repeat (960) begin
			@(negedge clk);
			for (int k = 0; k < 9; k++) begin
				if (d[k] == 0 && ref_d[3] == ref_d[1] && ref_d[2] == ref_d[1])
					check(out_clock[k] === ref_d[2], "ref copy");
				tog[k] += int'(out_clock[k] !== last[k]);
			end
			last = out_clock;
		end
		for (int k = 0; k < 9; k++)
			if (d[k] != 0)
				check(tog[k]*d[k] - 60 <= d[k] && 60 - tog[k]*d[k] <= d[k],
					"divided output rate");
	endtask

	// Waits out the settle time, then checks the applied word.
	task automatic apply_check(input logic [159:0] w);
		int n;
		n = 0;
		while (locked !== 1'b0 && n < 10) begin
			@(negedge clk);
			n++;
		end
		check(locked === 1'b0, "no settle");
		n = 0;
		while (locked !== 1'b1 && n < LOCK + 10) begin
			@(negedge clk);
			n++;
		end
		check(locked === 1'b1 && n >= LOCK - 4, "settle time");
		check(cap_en === w[0], "crystal cap");
		check_outputs(w, 1'b1);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial begin
		logic [159:0] w;
		repeat (20) @(posedge clk);
		check(pins.oe === 9'h000 && locked === 1'b1, "reset state");
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		check_outputs(model_latch, 1'b0);
		rand_word(w);
		host.send_bits(w, 160);
		pulse();
		apply_check(model_latch);
		// Reload while powered down; outputs stay off until power returns.
		@(posedge clk) pwr_n <= 1'b0;
		repeat (5) @(negedge clk);
		check(pins.oe === 9'h000 && out_clock === 9'h000, "off");
		rand_word(w);
		host.send_bits(w, 160);
		pulse();
		repeat (LOCK + 20) @(posedge clk);
		check(pins.oe === 9'h000, "off after load");
		pwr_n <= 1'b1;
		repeat (6) @(posedge clk);
		check(cap_en === model_latch[0], "cap after power");
		check_outputs(model_latch, 1'b1);
		// Strobe held high: every shifted bit reaches the latch at once.
		rand_word(w);
		host.set_strobe(1'b1);
		host.send_bits(w, 5);
		host.set_strobe(1'b0);
		apply_check(model_latch);
		report_and_stop();
	end

	// Cut a hang well beyond the expected run of about 7000 cycles.
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("unexpected at %0t: watchdog", $time);
		report_and_stop();
	end
endmodule

// ==== hw/cfg_loader_pkg.sv ====
// Notes on behaviour
// - Shift 160 bits in, most significant first.
// - Strobe rise latches word; outputs settle within 10 ms.
// - Strobe high passes each shifted bit to latch.
// - Power-down low tri-states all outputs, freezes dividers.
// - Unprogrammed outputs carry the buffered reference.
// - Power-up after strobe gives the programmed frequencies.
// - New loads accepted anytime, no reset needed.
// - One configuration bit enables crystal load capacitors.
package cfg_loader_pkg;

	// ======================================================
	// Configuration word layout
	localparam int CFG_BITS = 160;
	localparam int NUM_OUTS = 9;
	localparam int DIV_W = 4;
	localparam int DIV_LSB = 1;
	localparam int CAP_BIT = 0;
	localparam logic [DIV_W-1:0] DIV_BYPASS = 4'h0;

	// ======================================================
	// Timing
	localparam int LOCK_TIME_MS = 10;
	localparam int CLK_FREQ_KHZ = 50000;
	localparam int LOCK_CYCLES = LOCK_TIME_MS * CLK_FREQ_KHZ;
	localparam int LOCK_W = 20;

	// ======================================================
	// Carriers and state
	typedef struct packed {
		logic sclk;
		logic data;
		logic strobe;
		logic pwr_n;
		logic ref_clk;
	} pin_in_s;

	typedef struct packed {
		logic [NUM_OUTS-1:0] level;
		logic [NUM_OUTS-1:0] oe;
	} clock_pins_s;

	typedef struct packed {
		logic [CFG_BITS-1:0] shift;
		logic [CFG_BITS-1:0] latch;
		logic loaded;
	} latch_state_s;

	typedef struct packed {
		pin_in_s sync1;
		pin_in_s sync2;
		pin_in_s sync3;
		logic [NUM_OUTS*DIV_W-1:0] active_div;
		logic active_cap;
		logic pending;
		logic [LOCK_W-1:0] lock_cnt;
		logic programmed;
		logic [NUM_OUTS-1:0][DIV_W-1:0] div_cnt;
		clock_pins_s pins;
	} top_state_s;

endpackage

// ==== hw/cfg_shift_latch.sv ====
module cfg_shift_latch (
	// Clock and control
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Serial events, already synchronised
	input wire logic shift_pulse,
	input wire logic shift_bit,
	input wire logic load_pulse,
	input wire logic pass_through,
	// Latched word
	output logic [cfg_loader_pkg::CFG_BITS-1:0] latch_q,
	output logic loaded_q
);

	cfg_loader_pkg::latch_state_s st_q;
	cfg_loader_pkg::latch_state_s st_d;
	logic [cfg_loader_pkg::CFG_BITS-1:0] shifted;

	// ======================================================
	// Next state
	// A load and a shift in the same cycle latch the word including
	// the new bit, so a late strobe never drops the last bit.
	always_comb begin
		st_d = st_q;
		shifted = {st_q.shift[cfg_loader_pkg::CFG_BITS-2:0], shift_bit};
		st_d.loaded = 1'b0;
		if (shift_pulse) begin
			st_d.shift = shifted;
		end
		if (load_pulse || (pass_through && shift_pulse)) begin
			st_d.latch = shift_pulse ? shifted : st_q.shift;
			st_d.loaded = 1'b1;
		end
	end

	// ======================================================
	// State register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign latch_q = st_q.latch;
	assign loaded_q = st_q.loaded;

	// ======================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_shift_msb_first: assert property (
		shift_pulse && clk_en |=>
		st_q.shift == {$past(st_q.shift[cfg_loader_pkg::CFG_BITS-2:0]),
			$past(shift_bit)})
	else $error("Shift register did not take the bit at the bottom.");

	a_strobe_latch: assert property (
		load_pulse && !shift_pulse && clk_en |=>
		latch_q == $past(st_q.shift) && loaded_q)
	else $error("Strobe rise did not copy the shift register.");

	a_pass_through: assert property (
		pass_through && shift_pulse && clk_en |=> latch_q == st_q.shift)
	else $error("Held strobe did not pass shifted data to the latch.");

endmodule

// ==== hw/serial_clock_config_loader.sv ====
module serial_clock_config_loader #(
	parameter int LOCK_CYCLES = cfg_loader_pkg::LOCK_CYCLES
) (
	// Clock, reset and freeze
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Programming pins and reference, asynchronous to clk
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic load_strobe,
	input wire logic power_down_tristate_n,
	input wire logic reference_input,
	// Clock outputs, index 0 is out_clock_1
	output cfg_loader_pkg::clock_pins_s clock_pins,
	// Status
	output logic xtal_cap_enable,
	output logic config_locked
);

	localparam logic [cfg_loader_pkg::LOCK_W-1:0] LOCK_LAST =
		cfg_loader_pkg::LOCK_W'(LOCK_CYCLES - 1);

	cfg_loader_pkg::top_state_s st_q;
	cfg_loader_pkg::top_state_s st_d;
	cfg_loader_pkg::pin_in_s pins_in;
	logic shift_pulse;
	logic load_pulse;
	logic ref_rise;
	logic loaded;
	logic apply;
	logic [cfg_loader_pkg::CFG_BITS-1:0] latch_word;
	logic [cfg_loader_pkg::NUM_OUTS-1:0] lvl_nx;
	logic [cfg_loader_pkg::NUM_OUTS-1:0][cfg_loader_pkg::DIV_W-1:0] div_nx;

	// ======================================================
	// Pin sampling
	// Every pin goes through two flops; edges are found between the
	// second and third stage. The shift clock must stay below a
	// quarter of clk, well under what the pins themselves allow.
	assign pins_in.sclk = serial_clock;
	assign pins_in.data = serial_data;
	assign pins_in.strobe = load_strobe;
	assign pins_in.pwr_n = power_down_tristate_n;
	assign pins_in.ref_clk = reference_input;

	// Edge events on the synchronised pins.
	assign shift_pulse = st_q.sync2.sclk && !st_q.sync3.sclk;
	assign load_pulse = st_q.sync2.strobe && !st_q.sync3.strobe;
	assign ref_rise = st_q.sync2.ref_clk && !st_q.sync3.ref_clk;

	// ======================================================
	// Shift register and configuration latch
	cfg_shift_latch u_latch (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.shift_pulse(shift_pulse),
		.shift_bit(st_q.sync2.data),
		.load_pulse(load_pulse),
		.pass_through(st_q.sync2.strobe),
		.latch_q(latch_word),
		.loaded_q(loaded)
	);

	// ======================================================
	// Output clock generation
	// Each output either follows the reference or toggles after a
	// programmed count of reference rises. This stands in for the
	// analog synthesis, which is outside this block.
	for (genvar i = 0; i < cfg_loader_pkg::NUM_OUTS; i++) begin : g_out
		logic [cfg_loader_pkg::DIV_W-1:0] fld;
		logic bypass;
		logic wrap;

		assign fld = st_q.active_div[i*cfg_loader_pkg::DIV_W +:
			cfg_loader_pkg::DIV_W];
		// Until a word is applied every output is the reference.
		assign bypass = !st_q.programmed ||
			fld == cfg_loader_pkg::DIV_BYPASS;
		assign wrap = st_q.div_cnt[i] >= fld - 4'h1;
		// Power-down parks the pin low and freezes the divider.
		assign lvl_nx[i] = !st_q.sync2.pwr_n ? 1'b0 :
			bypass ? st_q.sync2.ref_clk :
			(ref_rise && wrap) ? !st_q.pins.level[i] :
			st_q.pins.level[i];
		assign div_nx[i] = !st_q.sync2.pwr_n ? st_q.div_cnt[i] :
			bypass ? 4'h0 :
			!ref_rise ? st_q.div_cnt[i] :
			wrap ? 4'h0 : st_q.div_cnt[i] + 4'h1;
	end

	// The settle timer has run out on this cycle.
	assign apply = st_q.pending && st_q.lock_cnt == LOCK_LAST;

	// ======================================================
	// Next state
	// The latched word takes effect only when the settle timer runs
	// out, so the outputs switch once and cleanly. A fresh load
	// restarts the timer; an expiry in the same cycle still applies the word.
	always_comb begin
		st_d = st_q;
		st_d.sync1 = pins_in;
		st_d.sync2 = st_q.sync1;
		st_d.sync3 = st_q.sync2;
		st_d.pins.oe = {cfg_loader_pkg::NUM_OUTS{st_q.sync2.pwr_n}};
		st_d.pins.level = lvl_nx;
		st_d.div_cnt = div_nx;
		if (apply) begin
			st_d.active_div = latch_word[cfg_loader_pkg::DIV_LSB +:
				cfg_loader_pkg::NUM_OUTS*cfg_loader_pkg::DIV_W];
			st_d.active_cap = latch_word[cfg_loader_pkg::CAP_BIT];
			st_d.programmed = 1'b1;
			st_d.pending = 1'b0;
		end else if (st_q.pending) begin
			st_d.lock_cnt = st_q.lock_cnt + 20'h00001;
		end
		if (loaded) begin
			st_d.pending = 1'b1;
			st_d.lock_cnt = '0;
		end
	end

	// ======================================================
	// State register
	// The latch survives power-down, so raising the pin again brings
	// back the programmed frequencies without a new load.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// ======================================================
	// Outputs
	assign clock_pins = st_q.pins;
	assign xtal_cap_enable = st_q.active_cap;
	assign config_locked = !st_q.pending;

	// ======================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_sclk_rise;
		st_q.sync2.sclk && !st_q.sync3.sclk;
	endsequence

	sequence s_strobe_rise;
		st_q.sync2.strobe && !st_q.sync3.strobe;
	endsequence

	sequence s_timer_done;
		st_q.pending && st_q.lock_cnt == LOCK_LAST && !loaded && clk_en;
	endsequence

	a_shift_on_rise: assert property (
		s_sclk_rise |-> shift_pulse ##1 !shift_pulse || !clk_en)
	else $error("Shift pulse not single on shift clock rise.");

	a_strobe_on_rise: assert property (
		s_strobe_rise ##0 clk_en |=> loaded)
	else $error("Strobe rise did not load the latch.");

	a_load_restarts: assert property (
		loaded && clk_en |=> st_q.pending && st_q.lock_cnt == '0 &&
		!config_locked)
	else $error("Load did not restart the settle timer.");

	a_settle_apply: assert property (
		s_timer_done |=> st_q.programmed && config_locked &&
		st_q.active_div == $past(latch_word[cfg_loader_pkg::DIV_LSB +:
			cfg_loader_pkg::NUM_OUTS*cfg_loader_pkg::DIV_W]))
	else $error("Settled word was not applied.");

	a_settle_bound: assert property (
		st_q.lock_cnt <= LOCK_LAST)
	else $error("Settle timer ran past its limit.");

	a_cap_select: assert property (
		s_timer_done |=>
		xtal_cap_enable == $past(latch_word[cfg_loader_pkg::CAP_BIT]))
	else $error("Crystal capacitor select did not follow the word.");

	a_power_down: assert property (
		!st_q.sync2.pwr_n && clk_en |=>
		clock_pins.oe == '0 && clock_pins.level == '0)
	else $error("Outputs driven during power-down.");

	a_power_up: assert property (
		st_q.sync2.pwr_n && clk_en |=> clock_pins.oe == '1)
	else $error("Outputs not enabled after power-up.");

	a_unprog_ref: assert property (
		!st_q.programmed && st_q.sync2.pwr_n && clk_en |=>
		clock_pins.level ==
		{cfg_loader_pkg::NUM_OUTS{$past(st_q.sync2.ref_clk)}})
	else $error("Unprogrammed outputs do not follow the reference.");

endmodule
